/* prm_pkg.sv */
package prm_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int          PRM_ADDR_W    = 16;                // Address port width
    localparam int          PRM_DATA_W    = 8;                 // Data port width
    localparam int          PRM_ROM_DEPTH = 65536;             // Byte cells in the array
    localparam logic [15:0] PRM_SEC_ADDR  = 16'hFFFF;          // Security register select
    localparam logic [7:0]  PRM_ERASED    = 8'hFF;             // Erased byte value
    localparam logic [7:0]  PRM_ERASE_KEY = 8'hFF;             // Data needed to start erase
    localparam logic [7:0]  PRM_LOCK_DATA = 8'hFF;             // Shown while reads are refused

    // ----------------------------------------------------------------
    // Security register fields and reset value
    // ----------------------------------------------------------------
    localparam int          PRM_SEC_W        = 2;              // Security register width
    localparam int          PRM_SEC_LOCK_POS = 0;              // Lock bit position
    localparam int          PRM_SEC_TBL_POS  = 1;              // Table read restrict position
    localparam logic [1:0]  PRM_SEC_RESET    = 2'h3;           // Erased: both bits one

    // ----------------------------------------------------------------
    // Programming-voltage pin levels
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PRM_VPP_LOW,                                           // Logic low
        PRM_VPP_HIGH,                                          // Logic high (read level)
        PRM_VPP_PROG,                                          // Program level
        PRM_VPP_ERASE                                          // Erase level
    } prm_vpp_t;

    // ----------------------------------------------------------------
    // Decoded programming operations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PRM_OP_NONE,                                           // Not in mode or no match
        PRM_OP_READ,                                           // Read byte
        PRM_OP_OUT_DIS,                                        // Output disable
        PRM_OP_PROG,                                           // Program byte
        PRM_OP_PROG_VFY,                                       // Program verify
        PRM_OP_ERASE,                                          // Bulk erase
        PRM_OP_ERASE_VFY,                                      // Erase verify
        PRM_OP_INHIBIT                                         // Program/erase inhibit
    } prm_op_t;

    // ----------------------------------------------------------------
    // Pin bundle from the programmer
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        rst_pin;                                  // Reset pin level
        logic        ale;                                      // Address latch strobe
        logic        program_store_strobe_n;                   // Program store strobe
        logic        erase_select_ctrl;                        // Erase select
        logic        mode_select_hi_a;                         // Mode select A
        logic        mode_select_hi_b;                         // Mode select B
        logic        mode_select_out_ctrl;                     // Mode select out control
        logic        chip_en_n;                                // Chip enable strobe
        logic        out_en_n;                                 // Output enable strobe
        prm_vpp_t    vpp;                                      // Programming voltage level
        logic [15:0] addr;                                     // Address port
        logic [7:0]  data;                                     // Data port input
    } prm_pins_t;

    localparam int PRM_PINS_W = $bits(prm_pins_t);             // Synchroniser width

endpackage

/* prm_sync2.sv */
`timescale 1ns/100ps

module prm_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;                                // First stage, read only below

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    // Stage one feeds stage two and nothing else
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule

/* prm_rom_prog.sv */
`timescale 1ns/100ps

// Function
// - Mode needs reset high, ALE low, strobe high
// - Output enable high keeps data port released
// - Program ANDs presented data into addressed byte
// - Bulk erase needs select, A0 low, ones
// - Erase sets every cell and security bit
// - Erase verify returns addressed byte
// - Both strobes high inhibit program and erase
// - Security register reachable only in mode
// - Security register at all-ones address
// - Cleared security bit stays until erase or system reset
// - Lock bit zero refuses all programmer reads; table reads are not affected
// - Restrict zero: external table reads stay external
// - Internal table reads always reach the array
// - Restrict one: no table read restriction
module prm_rom_prog
    import prm_pkg::*;
(
    // Clock and reset
    input  wire logic        I_REF_CLK,
    input  wire logic        I_SYS_RST,
    // Mode entry pins
    input  wire logic        I_RST_PIN,
    input  wire logic        I_ALE,
    input  wire logic        I_PROGRAM_STORE_STROBE_N,
    // Mode select pins
    input  wire logic        I_ERASE_SELECT_CTRL,
    input  wire logic        I_MODE_SELECT_HI_A,
    input  wire logic        I_MODE_SELECT_HI_B,
    input  wire logic        I_MODE_SELECT_OUT_CTRL,
    // Strobes and programming voltage
    input  wire logic        I_CHIP_EN_N,
    input  wire logic        I_OUT_EN_N,
    input  wire logic [1:0]  I_VPP_LEVEL,
    // Address and data ports
    input  wire logic [15:0] I_ADDR,
    input  wire logic [7:0]  I_DATA,
    output logic      [7:0]  O_DATA,
    output logic             O_DATA_OE,
    // Code table read from the core
    input  wire logic        I_TBL_REQ,
    input  wire logic        I_TBL_FROM_EXT,
    input  wire logic [15:0] I_TBL_ADDR,
    output logic             O_TBL_USE_INT,
    output logic             O_TBL_VALID,
    output logic      [7:0]  O_TBL_DATA,
    // Status
    output logic             O_PROG_MODE,
    output logic             O_LOCK_BIT,
    output logic             O_TABLE_READ_RESTRICT_BIT
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    prm_pins_t            pins_async;                          // Raw pin bundle
    prm_pins_t            pins;                                // Synchronised pin bundle
    prm_op_t              op;                                  // Decoded operation
    prm_op_t              op_prev_reg;                         // Operation last cycle
    logic                 prog_mode;                           // Mode entry satisfied
    logic                 sec_sel;                             // Security register addressed
    logic                 start_prog;                          // One pulse per program pulse
    logic                 start_erase;                         // One pulse per erase pulse
    logic                 rd_op;                               // A read-type operation
    logic [7:0]           rom_mem [PRM_ROM_DEPTH];             // Array cells
    logic [PRM_SEC_W-1:0] sec_reg;                             // Security register
    logic [7:0]           rd_byte;                             // Byte chosen for readout
    logic [7:0]           data_next;                           // Next data port value
    logic                 data_oe_next;                        // Next data port enable
    logic                 tbl_int;                             // Table read may use array

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    // Every programmer pin is asynchronous to our clock
    assign pins_async = '{
        rst_pin:                I_RST_PIN,
        ale:                    I_ALE,
        program_store_strobe_n: I_PROGRAM_STORE_STROBE_N,
        erase_select_ctrl:      I_ERASE_SELECT_CTRL,
        mode_select_hi_a:       I_MODE_SELECT_HI_A,
        mode_select_hi_b:       I_MODE_SELECT_HI_B,
        mode_select_out_ctrl:   I_MODE_SELECT_OUT_CTRL,
        chip_en_n:              I_CHIP_EN_N,
        out_en_n:               I_OUT_EN_N,
        vpp:                    prm_vpp_t'(I_VPP_LEVEL),
        addr:                   I_ADDR,
        data:                   I_DATA
    };

    prm_sync2 #(
        .WIDTH (PRM_PINS_W)
    ) u_sync (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_SYS_RST),
        .i_async (pins_async),
        .o_sync  (pins)
    );

    // ----------------------------------------------------------------
    // Operation decode
    // ----------------------------------------------------------------
    // Mode entry gate; nothing decodes outside it
    function automatic logic in_mode(input prm_pins_t p);
        in_mode = p.rst_pin && !p.ale && p.program_store_strobe_n;
    endfunction

    // Pin pattern to operation
    function automatic prm_op_t decode_op(input prm_pins_t p);
        logic sel_ok;
        sel_ok    = !p.mode_select_hi_a && !p.mode_select_hi_b
                    && !p.mode_select_out_ctrl;
        decode_op = PRM_OP_NONE;
        if (!in_mode(p) || !sel_ok) begin
            decode_op = PRM_OP_NONE;
        end else if (p.chip_en_n && p.out_en_n) begin
            // Checked first so the shared bus cannot reach this part
            decode_op = PRM_OP_INHIBIT;
        end else if (!p.chip_en_n && !p.out_en_n) begin
            if (p.vpp == PRM_VPP_HIGH && !p.erase_select_ctrl) begin
                decode_op = PRM_OP_READ;
            end
        end else if (!p.chip_en_n && p.out_en_n) begin
            if (p.vpp == PRM_VPP_PROG && !p.erase_select_ctrl) begin
                decode_op = PRM_OP_PROG;
            end else if (p.vpp == PRM_VPP_ERASE && p.erase_select_ctrl
                         && !p.addr[0] && p.data == PRM_ERASE_KEY) begin
                decode_op = PRM_OP_ERASE;
            end else begin
                decode_op = PRM_OP_OUT_DIS;
            end
        end else begin
            // Chip enable high, output enable low: verify reads
            if (p.vpp == PRM_VPP_PROG && !p.erase_select_ctrl) begin
                decode_op = PRM_OP_PROG_VFY;
            end else if (p.vpp == PRM_VPP_ERASE && p.erase_select_ctrl) begin
                decode_op = PRM_OP_ERASE_VFY;
            end
        end
    endfunction

    assign prog_mode = in_mode(pins);
    assign op        = decode_op(pins);
    assign sec_sel   = (pins.addr == PRM_SEC_ADDR);

    // Act once per strobe pulse, not on every held cycle
    assign start_prog  = (op == PRM_OP_PROG) && (op_prev_reg != PRM_OP_PROG);
    assign start_erase = (op == PRM_OP_ERASE) && (op_prev_reg != PRM_OP_ERASE);

    // ----------------------------------------------------------------
    // Operation history
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            op_prev_reg <= PRM_OP_NONE;
        end else begin
            op_prev_reg <= op;
        end
    end

    // ----------------------------------------------------------------
    // Array cells
    // ----------------------------------------------------------------
    // Not reset: contents stand for nonvolatile storage.
    // Programming only clears bits; erase is the one way back to one.
    always_ff @(posedge I_REF_CLK) begin
        if (start_erase) begin
            for (int i = 0; i < PRM_ROM_DEPTH; i++) begin
                rom_mem[i] <= PRM_ERASED;
            end
        end else if (start_prog && !sec_sel) begin
            rom_mem[pins.addr] <= rom_mem[pins.addr] & pins.data;
        end
    end

    // ----------------------------------------------------------------
    // Security register
    // ----------------------------------------------------------------
    // Written only by system reset and the programming decode, never by the core
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            sec_reg <= PRM_SEC_RESET;
        end else if (start_erase) begin
            sec_reg <= PRM_SEC_RESET;
        end else if (start_prog && sec_sel) begin
            // AND keeps a cleared bit cleared
            sec_reg <= sec_reg & pins.data[PRM_SEC_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Programmer readout
    // ----------------------------------------------------------------
    assign rd_op = (op == PRM_OP_READ) || (op == PRM_OP_PROG_VFY)
                   || (op == PRM_OP_ERASE_VFY);

    // Pick array byte or security register
    always_comb begin
        rd_byte = rom_mem[pins.addr];
        if (sec_sel) begin
            rd_byte = {{(PRM_DATA_W - PRM_SEC_W){1'b1}}, sec_reg};
        end
    end

    // Drive only for a read-type decode with output enable low
    always_comb begin
        data_next    = '0;
        data_oe_next = 1'b0;
        if (rd_op && !pins.out_en_n) begin
            data_oe_next = 1'b1;
            data_next    = rd_byte;
            if (!sec_reg[PRM_SEC_LOCK_POS]) begin
                // Locked part shows a fixed pattern, never real contents
                data_next = PRM_LOCK_DATA;
            end
        end
    end

    // Data port flops
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_DATA    <= '0;
            O_DATA_OE <= 1'b0;
        end else begin
            O_DATA    <= data_next;
            O_DATA_OE <= data_oe_next;
        end
    end

    // ----------------------------------------------------------------
    // Code table read path
    // ----------------------------------------------------------------
    // Internal fetch always reaches the array; external only if allowed
    assign tbl_int = !I_TBL_FROM_EXT
                     || sec_reg[PRM_SEC_TBL_POS];

    // Registered answer one cycle after the request
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_TBL_VALID   <= 1'b0;
            O_TBL_USE_INT <= 1'b0;
            O_TBL_DATA    <= '0;
        end else begin
            O_TBL_VALID <= I_TBL_REQ;
            if (I_TBL_REQ) begin
                O_TBL_USE_INT <= tbl_int;
                // Security bits never appear here, only array bytes or zero
                O_TBL_DATA    <= tbl_int ? rom_mem[I_TBL_ADDR] : '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_PROG_MODE               <= 1'b0;
            O_LOCK_BIT                <= 1'b1;
            O_TABLE_READ_RESTRICT_BIT <= 1'b1;
        end else begin
            O_PROG_MODE               <= prog_mode;
            O_LOCK_BIT                <= sec_reg[PRM_SEC_LOCK_POS];
            O_TABLE_READ_RESTRICT_BIT <= sec_reg[PRM_SEC_TBL_POS];
        end
    end

endmodule

/* prm_rom_prog_checker.sv */
`timescale 1ns/100ps

// ------------------------------------
// Pin-level checker for the ROM port
// ------------------------------------
module prm_rom_prog_checker
    import prm_pkg::*;
(
    // Clock, reset and programmer pins
    input wire logic        I_REF_CLK,
    input wire logic        I_SYS_RST,
    input wire logic        I_RST_PIN,
    input wire logic        I_ALE,
    input wire logic        I_PROGRAM_STORE_STROBE_N,
    input wire logic        I_ERASE_SELECT_CTRL,
    input wire logic        I_CHIP_EN_N,
    input wire logic        I_OUT_EN_N,
    input wire logic [1:0]  I_VPP_LEVEL,
    input wire logic [15:0] I_ADDR,
    input wire logic [7:0]  I_DATA,
    input wire logic        I_TBL_REQ,
    input wire logic        I_TBL_FROM_EXT,
    // Outputs under watch
    input wire logic [7:0]  O_DATA,
    input wire logic        O_DATA_OE,
    input wire logic        O_TBL_USE_INT,
    input wire logic        O_TBL_VALID,
    input wire logic [7:0]  O_TBL_DATA,
    input wire logic        O_PROG_MODE,
    input wire logic        O_LOCK_BIT,
    input wire logic        O_TABLE_READ_RESTRICT_BIT
);
    logic [2:0] settle_reg;      // Cycles since reset, saturating
    logic [5:0] erase_hist_reg;  // Recent valid erase patterns
    logic       settled;         // Sync pipeline flushed
    logic       mode_raw;        // Mode entry at the pins
    logic       erase_raw;       // Valid erase pattern at the pins
    logic       inh_raw;         // Both strobes high
    assign settled   = (settle_reg == 3'h7);
    assign mode_raw  = I_RST_PIN && !I_ALE && I_PROGRAM_STORE_STROBE_N;
    assign inh_raw   = I_CHIP_EN_N && I_OUT_EN_N;
    assign erase_raw = mode_raw && I_ERASE_SELECT_CTRL && !I_CHIP_EN_N && I_OUT_EN_N
                       && (I_VPP_LEVEL == 2'h3) && !I_ADDR[0] && (I_DATA == PRM_ERASE_KEY);
    // Pins act three edges late, so history is kept for the checks
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            settle_reg     <= 3'h0;
            erase_hist_reg <= 6'h00;
        end else begin
            settle_reg     <= settled ? settle_reg : settle_reg + 3'h1;
            erase_hist_reg <= {erase_hist_reg[4:0], erase_raw};
        end
    end
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    sequence tbl_answer;
        ##1 O_TBL_VALID;
    endsequence
    sequence sec_ones;
        ##[1:2] (O_LOCK_BIT && O_TABLE_READ_RESTRICT_BIT);
    endsequence
    chk_tbl_answer: assert property (I_TBL_REQ |-> tbl_answer)
        else $error("table read not answered next cycle");
    chk_tbl_idle: assert property (!I_TBL_REQ |=> !O_TBL_VALID)
        else $error("table answer without request");
    chk_tbl_route: assert property (I_TBL_REQ |=> O_TBL_USE_INT ==
        (!$past(I_TBL_FROM_EXT) || $past(O_TABLE_READ_RESTRICT_BIT)))
        else $error("table read routed to wrong memory");
    chk_tbl_ext_zero: assert property (I_TBL_REQ ##1 !O_TBL_USE_INT |-> O_TBL_DATA == 8'h00)
        else $error("external table read leaked array data");
    chk_oe_release: assert property (settled && $past(I_OUT_EN_N, 3) |-> !O_DATA_OE)
        else $error("data port driven with output enable high");
    chk_mode_off: assert property (settled && !$past(mode_raw, 3) |-> !O_DATA_OE)
        else $error("data port driven outside the mode");
    chk_mode_flag: assert property (settled && !$past(mode_raw, 2) && !$past(mode_raw, 3)
        && !$past(mode_raw, 4) |-> !O_PROG_MODE)
        else $error("mode flag set without entry pins");
    chk_inhibit_sec: assert property (settled && $past(inh_raw, 2) && $past(inh_raw, 3)
        && $past(inh_raw, 4) |-> $stable(O_LOCK_BIT) && $stable(O_TABLE_READ_RESTRICT_BIT))
        else $error("security bits changed while inhibited");
    chk_sec_sticky: assert property (settled && ($rose(O_LOCK_BIT)
        || $rose(O_TABLE_READ_RESTRICT_BIT)) |-> (erase_hist_reg != 6'h00))
        else $error("security bit returned to one without erase");
    chk_erase_ones: assert property (settled && erase_hist_reg[2] && !erase_hist_reg[3]
        |-> sec_ones)
        else $error("erase did not set the security bits");
    chk_lock_read: assert property (!O_LOCK_BIT && !$past(O_LOCK_BIT)
        && !$past(O_LOCK_BIT, 2) && O_DATA_OE |-> O_DATA == PRM_LOCK_DATA)
        else $error("locked part returned real data");
endmodule

/* prm_programmer.sv */
`timescale 1ns/100ps

// ------------------------------------
// Parallel programmer model
// ------------------------------------
module prm_programmer
    import prm_pkg::*;
(
    // Clock and device data port
    input  wire logic       i_clk,
    input  wire logic [7:0] i_dev_data,
    input  wire logic       i_dev_oe,
    // Pins toward the device
    output prm_pins_t       o_pins,
    output logic      [7:0] o_bus
);
    prm_pins_t  pins_reg;           // Driven pin levels
    logic       drv_reg  = 1'b0;    // Programmer drives the data port
    logic [7:0] last_reg = 8'h00;   // Last data port level
    assign o_pins = pins_reg;
    // Floating port shows a changing pattern so stale data never passes
    assign o_bus = drv_reg ? pins_reg.data : (i_dev_oe ? i_dev_data : ~last_reg);
    always @(posedge i_clk) last_reg <= o_bus;
    // Idle: mode held, both strobes high so nothing is written
    initial begin
        pins_reg           = '0;
        pins_reg.vpp       = PRM_VPP_HIGH;
        pins_reg.chip_en_n = 1'b1;
        pins_reg.out_en_n  = 1'b1;
        set_mode(1'b1, 1'b0, 1'b1);
    end
    task automatic set_mode(input logic rst, input logic ale, input logic strb);
        pins_reg.rst_pin                = rst;
        pins_reg.ale                    = ale;
        pins_reg.program_store_strobe_n = strb;
    endtask
    // One pattern, held long enough for sync and output flop
    task automatic step(input logic ce_n, input logic oe_n, input prm_vpp_t vpp,
                        input logic sel, input logic [15:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        #1;
        pins_reg.chip_en_n         = ce_n;
        pins_reg.out_en_n          = oe_n;
        pins_reg.vpp               = vpp;
        pins_reg.erase_select_ctrl = sel;
        pins_reg.addr              = addr;
        pins_reg.data              = data;
        drv_reg                    = oe_n;
        repeat (5) @(posedge i_clk);
        #1;
    endtask
    // Every write is followed by its verify read
    task automatic write_byte(input logic [15:0] addr, input logic [7:0] data);
        step(1'b0, 1'b1, PRM_VPP_PROG, 1'b0, addr, data);
        step(1'b1, 1'b0, PRM_VPP_PROG, 1'b0, addr, 8'h00);
    endtask
    task automatic erase(input logic [7:0] key);
        step(1'b0, 1'b1, PRM_VPP_ERASE, 1'b1, 16'h0000, key);
    endtask
endmodule

/* prm_rom_prog_bench.sv */
`timescale 1ns/100ps

// ------------------------------------
// ROM programming port bench
// ------------------------------------
module prm_rom_prog_bench
    import prm_pkg::*;
;
    logic        clk, rst;                       // Clock and reset
    logic        tbl_req, tbl_ext;               // Table read request
    logic [15:0] tbl_addr;                       // Table read address
    prm_pins_t   pins;                           // Programmer pins
    logic [7:0]  bus, dout, tdata;               // Data port and outputs
    logic        doe, use_int, tvalid, pmode, lock, restr;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    prm_programmer prm_programmer_i (.i_clk(clk), .i_dev_data(dout), .i_dev_oe(doe),
        .o_pins(pins), .o_bus(bus));
    prm_rom_prog prm_rom_prog_i (.I_REF_CLK(clk), .I_SYS_RST(rst),
        .I_RST_PIN(pins.rst_pin), .I_ALE(pins.ale),
        .I_PROGRAM_STORE_STROBE_N(pins.program_store_strobe_n),
        .I_ERASE_SELECT_CTRL(pins.erase_select_ctrl), .I_MODE_SELECT_HI_A(pins.mode_select_hi_a),
        .I_MODE_SELECT_HI_B(pins.mode_select_hi_b),
        .I_MODE_SELECT_OUT_CTRL(pins.mode_select_out_ctrl), .I_CHIP_EN_N(pins.chip_en_n),
        .I_OUT_EN_N(pins.out_en_n), .I_VPP_LEVEL(pins.vpp), .I_ADDR(pins.addr), .I_DATA(bus),
        .I_TBL_REQ(tbl_req), .I_TBL_FROM_EXT(tbl_ext), .I_TBL_ADDR(tbl_addr),
        .O_DATA(dout), .O_DATA_OE(doe), .O_TBL_USE_INT(use_int), .O_TBL_VALID(tvalid),
        .O_TBL_DATA(tdata), .O_PROG_MODE(pmode), .O_LOCK_BIT(lock),
        .O_TABLE_READ_RESTRICT_BIT(restr));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic bits(input logic [1:0] exp);
        check("security bits", {6'h00, exp}, {6'h00, restr, lock});
    endtask
    task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
        prm_programmer_i.step(1'b0, 1'b0, PRM_VPP_HIGH, 1'b0, addr, 8'h00);
        check("drive enable", 8'h03, {6'h00, pmode, doe});
        check("read data", exp, bus);
    endtask
    task automatic wr(input logic [15:0] addr, input logic [7:0] data, input logic [7:0] exp);
        prm_programmer_i.write_byte(addr, data);
        check("verify data", exp, bus);
    endtask
    task automatic tbl(input logic ext, input logic [7:0] exp_int, input logic [7:0] exp);
        @(posedge clk);
        #1;
        tbl_req  = 1'b1;
        tbl_ext  = ext;
        tbl_addr = 16'h0010;
        @(posedge clk);
        #1;
        tbl_req = 1'b0;
        check("table valid", 8'h01, {7'h00, tvalid});
        check("table route", exp_int, {7'h00, use_int});
        check("table data", exp, tdata);
    endtask
    task automatic summarize();
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            $display("unexpected run length: expected end, seen %0d cycles", cycles);
            summarize();
        end
    end
    initial begin
        rst = 1'b1;
        tbl_req = 1'b0;
        tbl_ext = 1'b0;
        tbl_addr = 16'h0000;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        bits(2'h3);
        check("idle drive", 8'h00, {7'h00, doe});
        prm_programmer_i.erase(8'hFF);
        prm_programmer_i.step(1'b1, 1'b0, PRM_VPP_ERASE, 1'b1, 16'h1234, 8'h00);
        check("erase verify", 8'hFF, bus);
        rd(16'hFFFF, 8'hFF);
        wr(16'h1234, 8'hA5, 8'hA5);
        rd(16'h1234, 8'hA5);
        prm_programmer_i.step(1'b0, 1'b1, PRM_VPP_HIGH, 1'b0, 16'h1234, 8'h00);
        check("disabled drive", 8'h00, {7'h00, doe});
        wr(16'h1234, 8'h5A, 8'h00);
        prm_programmer_i.step(1'b1, 1'b1, PRM_VPP_PROG, 1'b0, 16'h0010, 8'h00);
        rd(16'h0010, 8'hFF);
        // Each entry pin wrong in turn: no write, no drive
        for (int i = 0; i < 3; i++) begin
            prm_programmer_i.set_mode(i != 0, i == 1, i != 2);
            prm_programmer_i.step(1'b0, 1'b1, PRM_VPP_PROG, 1'b0, 16'hFFFF, 8'h00);
            prm_programmer_i.step(1'b0, 1'b0, PRM_VPP_HIGH, 1'b0, 16'h1234, 8'h00);
            check("out of mode drive", 8'h00, {6'h00, pmode, doe});
            prm_programmer_i.set_mode(1'b1, 1'b0, 1'b1);
            bits(2'h3);
        end
        prm_programmer_i.erase(8'hFE);
        rd(16'h1234, 8'h00);
        prm_programmer_i.step(1'b0, 1'b1, PRM_VPP_ERASE, 1'b1, 16'h0001, 8'hFF);
        rd(16'h1234, 8'h00);
        wr(16'hFFFF, 8'hFD, 8'hFD);
        wr(16'hFFFF, 8'hFF, 8'hFD);
        bits(2'h1);
        tbl(1'b1, 8'h00, 8'h00);
        tbl(1'b0, 8'h01, 8'hFF);
        wr(16'hFFFF, 8'hFC, 8'hFF);
        bits(2'h0);
        rd(16'h1234, 8'hFF);
        prm_programmer_i.erase(8'hFF);
        bits(2'h3);
        tbl(1'b1, 8'h01, 8'hFF);
        summarize();
    end
endmodule

bind prm_rom_prog prm_rom_prog_checker prm_rom_prog_checker_i (.I_REF_CLK, .I_SYS_RST,
    .I_RST_PIN, .I_ALE, .I_PROGRAM_STORE_STROBE_N, .I_ERASE_SELECT_CTRL, .I_CHIP_EN_N,
    .I_OUT_EN_N, .I_VPP_LEVEL, .I_ADDR, .I_DATA, .I_TBL_REQ, .I_TBL_FROM_EXT, .O_DATA,
    .O_DATA_OE, .O_TBL_USE_INT, .O_TBL_VALID, .O_TBL_DATA, .O_PROG_MODE, .O_LOCK_BIT,
    .O_TABLE_READ_RESTRICT_BIT);
